// >>> ssc_control.sv
`default_nettype none
// Summary of operation
// R1: after reset, a 200 us initialisation NAKs every serial access
// R2: host stays silent and ignores outputs until initialisation ends
// R3: initialisation ends in SLEEP with oscillator and measurement off
// R4: serial core serves accesses during SLEEP without leaving SLEEP
// R5: setting power-on bit moves to IDLE, oscillator running, no measurement
// R6: measure enable 1 goes ACTIVE, 0 returns to IDLE
// R7: with sleep-after-irq set, any interrupt forces SLEEP
// R8: irq sleep keeps all registers; power-on bit stays, SLEEP overrides
// R9: irq sleep ends only when its flag is cleared via clear register
// R10: six channels, 16-bit counts, programmable gain and integration time
// R11: optional wait time inserted between consecutive measurements
// R12: host sets up diode multiplexer after power-up before measuring
// R13: mode 0 starts on enable, length from step count and size
// R14: mode 1 starts on sync pin edge, length from step count and size
// R15: mode 3 starts on pin edge, stops when edge count reached
// R16: mode 3 records elapsed integration time as 24-bit value
// R17: interrupt pin shows busy or ready in both sync modes
// R18: serial slave at 7-bit address 0x39, standard and fast speeds
// R19: 8-bit pointer increments per byte and survives STOP
// R20: reading a low byte latches the whole field for the high byte
// R21: host writes low byte first, high byte directly after
// R22: write is START, address, register, data, STOP, slave acks each
// R23: master acks each read byte but the last, then NACK and STOP
// R24: integration lasts (count+1) times (size+1) times 2.78 us; code rounds each step up to 28 clk cycles, 2.8 us
module ssc_control
	import ssc_pkg::*;
#(
	parameter int NUM_CH = 6
) (
	// system clock and reset
	input wire logic clk,
	input wire logic nrst,
	// serial link, own clock
	input wire logic linkClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// sync pin and interrupt
	input wire logic gpioIn,
	output logic irqN,
	// converter front end
	input wire logic [NUM_CH-1:0] convPulse,
	output logic oscEnable,
	output logic convRun,
	output logic diodeMuxEn,
	output logic [GAIN_W-1:0] chanGain
);
	if (NUM_CH < 1 || NUM_CH > 6) begin : g_bad_ch
		$error("NUM_CH must be 1 to 6");
	end

	localparam int INIT_W = $clog2(INIT_CYC + 1);
	localparam int BASE_W = $clog2(BASE_CYC + 1);
	localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYC - 1);
	localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_CYC - 1);
	localparam logic [23:0] ELAPSED_MAX = 24'hFFFFFF;
	localparam logic [15:0] CH_MAX = 16'hFFFF;

	// ---------------- link domain ----------------
	logic lkRstS1, linkRstN;
	logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3;
	logic initS1, initS2;
	logic [2:0] stS1, stS2;
	logic snapS1, snapS2, snapS3;
	ssc_link_t lk_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, tx_q, ptr_q, stepSizeLo_q;
	logic ack_q, goRd_q, mAck_q;
	logic [15:0] shadow_q;
	ssc_cfg_t cfgL_q;
	logic cfgTgl_q, clrTgl_q;
	logic [1:0] clrBits_q;
	logic [15:0] chL_q [NUM_CH];
	logic [23:0] elapsedL_q;
	logic sclRise, sclFall, startC, stopC, busy;
	logic wrStb, regStb, rdLoad;
	logic [7:0] rdByte, chOff;
	logic [15:0] rdUpper;
	logic rdIsLow;

	// ---------------- clk domain ----------------
	logic initDone_q;
	logic cfgS1, cfgS2, cfgS3, clrS1, clrS2, clrS3;
	logic gpS1, gpS2, gpS3;
	ssc_cfg_t cfg_q;
	logic [1:0] clrEvt_q;
	ssc_pwr_t pwr_q;
	ssc_meas_t ms_q;
	logic [INIT_W-1:0] initCnt_q;
	logic [BASE_W-1:0] base_q;
	logic [15:0] size_q;
	logic [7:0] count_q, edges_q;
	logic [23:0] elapsed_q, elapsedSnap_q;
	logic [15:0] cnt_q [NUM_CH];
	logic [15:0] chData_q [NUM_CH];
	logic snapTgl_q, irqSleep_q, intFlag_q, ready_q;
	logic tick, gpEdge, syncMode, integDone, waitDone, irqEvt, clrSleep, clrInt;

	// link reset release and input synchronisers
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			lkRstS1 <= 1'b0;
			linkRstN <= 1'b0;
		end else begin
			lkRstS1 <= 1'b1;
			linkRstN <= lkRstS1;
		end
	end

	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			{sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3} <= 6'h3F;
			{initS1, initS2, snapS1, snapS2, snapS3} <= 5'h00;
			stS1 <= 3'h0;
			stS2 <= 3'h0;
		end else begin
			sclS1 <= sclIn;
			sclS2 <= sclS1;
			sclS3 <= sclS2;
			sdaS1 <= sdaIn;
			sdaS2 <= sdaS1;
			sdaS3 <= sdaS2;
			initS1 <= initDone_q;
			initS2 <= initS1;
			stS1 <= {ready_q, intFlag_q, irqSleep_q};
			stS2 <= stS1;
			snapS1 <= snapTgl_q;
			snapS2 <= snapS1;
			snapS3 <= snapS2;
		end
	end

	assign sclRise = sclS2 & ~sclS3;
	assign sclFall = ~sclS2 & sclS3;
	assign startC = sclS2 & sclS3 & sdaS3 & ~sdaS2;
	assign stopC = sclS2 & sclS3 & ~sdaS3 & sdaS2;
	assign busy = (lk_q != LK_IDLE) & ~startC & ~stopC;
	assign regStb = busy & sclFall & (lk_q == LK_REG) & (bit_q == 4'h8) & ~ack_q;
	assign wrStb = busy & sclFall & (lk_q == LK_WR) & (bit_q == 4'h8) & ~ack_q;
	assign rdLoad = busy & sclFall & ((ack_q & goRd_q) |
		((lk_q == LK_RD) & (bit_q == 4'h8) & mAck_q));
	assign chOff = ptr_q - REG_CH0_L;

	// read data and the upper part to latch on a low-byte read
	always_comb begin
		rdByte = 8'h00;
		rdUpper = 16'h0000;
		rdIsLow = 1'b0;
		if (ptr_q >= REG_CH0_L && chOff < 8'(2 * NUM_CH)) begin
			if (!chOff[0]) begin
				rdByte = chL_q[chOff[3:1]][7:0];
				rdUpper = {8'h00, chL_q[chOff[3:1]][15:8]};
				rdIsLow = 1'b1; // see R20
			end else begin
				rdByte = shadow_q[7:0];
			end
		end else if (ptr_q == REG_ELAPSED_INTEGRATION_L) begin
			rdByte = elapsedL_q[7:0];
			rdUpper = elapsedL_q[23:8];
			rdIsLow = 1'b1; // see R16
		end else if (ptr_q == REG_ELAPSED_INTEGRATION_M) begin
			rdByte = shadow_q[7:0];
		end else if (ptr_q == REG_ELAPSED_INTEGRATION_H) begin
			rdByte = shadow_q[15:8];
		end else if (ptr_q == REG_CONFIG) begin
			rdByte = {6'h00, cfgL_q.intMode};
		end else if (ptr_q == REG_STAT) begin
			rdByte[READY_BIT] = stS2[2];
		end else if (ptr_q == REG_EDGE) begin
			rdByte = cfgL_q.syncEdges;
		end else if (ptr_q == REG_ENABLE) begin
			rdByte[EN_PON_BIT] = cfgL_q.powerOnBit;
			rdByte[EN_MEAS_BIT] = cfgL_q.measureEnable;
			rdByte[EN_WAIT_BIT] = cfgL_q.waitEnable;
			rdByte[EN_MUX_BIT] = cfgL_q.diodeMux;
		end else if (ptr_q == REG_STEP_COUNT) begin
			rdByte = cfgL_q.stepCount;
		end else if (ptr_q == REG_WAIT) begin
			rdByte = cfgL_q.interMeasureWait;
		end else if (ptr_q == REG_STATUS) begin
			rdByte[INT_FLAG_BIT] = stS2[1];
		end else if (ptr_q == REG_SLEEP_STAT) begin
			rdByte[SLEEP_FLAG_BIT] = stS2[0]; // see R9
		end else if (ptr_q == REG_GAIN) begin
			rdByte = {3'h0, cfgL_q.gain};
		end else if (ptr_q == REG_CFG_SLEEP) begin
			rdByte[SAI_BIT] = cfgL_q.sleepAfterIrq;
		end else if (ptr_q == REG_STEP_SIZE_L) begin
			rdByte = cfgL_q.stepSize[7:0];
			rdUpper = {8'h00, cfgL_q.stepSize[15:8]};
			rdIsLow = 1'b1;
		end else if (ptr_q == REG_STEP_SIZE_H) begin
			rdByte = shadow_q[7:0];
		end else if (ptr_q == REG_INT_ENABLE) begin
			rdByte[INT_EN_BIT] = cfgL_q.irqEnable;
		end
	end

	// serial slave byte engine, runs on the link clock even in SLEEP
	always_ff @(posedge linkClk or negedge linkRstN) begin // see R4
		if (!linkRstN) begin
			lk_q <= LK_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ack_q <= 1'b0;
			goRd_q <= 1'b0;
			mAck_q <= 1'b0;
			sdaOe <= 1'b0;
		end else if (startC) begin
			lk_q <= LK_ADDR; // see R22
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			goRd_q <= 1'b0;
			sdaOe <= 1'b0;
		end else if (stopC) begin
			lk_q <= LK_IDLE;
			sdaOe <= 1'b0;
		end else if (lk_q != LK_IDLE) begin
			if (sclRise && lk_q != LK_RD && !ack_q && bit_q != 4'h8) begin
				sh_q <= {sh_q[6:0], sdaS2};
				bit_q <= bit_q + 4'h1;
			end
			if (sclRise && lk_q == LK_RD && bit_q == 4'h8) begin
				mAck_q <= ~sdaS2; // see R23
			end
			if (rdLoad) begin
				tx_q <= rdByte;
				sdaOe <= ~rdByte[7];
				bit_q <= 4'h0;
				ack_q <= 1'b0;
				goRd_q <= 1'b0;
				lk_q <= LK_RD;
			end else if (sclFall) begin
				if (lk_q == LK_RD) begin
					if (bit_q == 4'h8) begin
						lk_q <= LK_IDLE;
					end else if (bit_q == 4'h7) begin
						sdaOe <= 1'b0;
						bit_q <= 4'h8;
					end else begin
						tx_q <= {tx_q[6:0], 1'b0};
						sdaOe <= ~tx_q[6];
						bit_q <= bit_q + 4'h1;
					end
				end else if (ack_q) begin
					ack_q <= 1'b0;
					sdaOe <= 1'b0;
					bit_q <= 4'h0;
				end else if (bit_q == 4'h8) begin
					case (lk_q)
						LK_ADDR: begin
							if (sh_q[7:1] == I2C_DEV_ADDR && initS2) begin // see R18, R1
								sdaOe <= 1'b1;
								ack_q <= 1'b1;
								goRd_q <= sh_q[0];
								lk_q <= sh_q[0] ? LK_ADDR : LK_REG;
							end else begin
								lk_q <= LK_IDLE;
							end
						end
						LK_REG: begin
							sdaOe <= 1'b1;
							ack_q <= 1'b1;
							lk_q <= LK_WR;
						end
						default: begin
							sdaOe <= 1'b1; // see R22
							ack_q <= 1'b1;
						end
					endcase
				end
			end
		end
	end

	// open-drain line only ever pulls low
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

	// register pointer kept across STOP
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			ptr_q <= 8'h00;
		end else if (regStb) begin
			ptr_q <= sh_q;
		end else if (wrStb || rdLoad) begin
			ptr_q <= ptr_q + 8'h01; // see R19
		end
	end

	// read latch for multi-byte fields
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			shadow_q <= 16'h0000;
		end else if (rdLoad && rdIsLow) begin
			shadow_q <= rdUpper; // see R20
		end
	end

	// result snapshot from the measurement side
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			elapsedL_q <= 24'h000000;
			for (int i = 0; i < NUM_CH; i++) begin
				chL_q[i] <= 16'h0000;
			end
		end else if (snapS2 != snapS3) begin
			elapsedL_q <= elapsedSnap_q;
			for (int i = 0; i < NUM_CH; i++) begin
				chL_q[i] <= chData_q[i];
			end
		end
	end

	// register writes and the event toggles toward the clk side
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			cfgL_q <= '0;
			stepSizeLo_q <= 8'h00;
			cfgTgl_q <= 1'b0;
			clrTgl_q <= 1'b0;
			clrBits_q <= 2'h0;
		end else if (wrStb) begin
			if (ptr_q == REG_CLEAR) begin
				clrBits_q <= {sh_q[CLR_INT_BIT], sh_q[CLR_SLEEP_BIT]}; // see R9
				clrTgl_q <= ~clrTgl_q;
			end else begin
				cfgTgl_q <= ~cfgTgl_q;
			end
			if (ptr_q == REG_CONFIG) begin
				cfgL_q.intMode <= sh_q[1:0];
			end else if (ptr_q == REG_EDGE) begin
				cfgL_q.syncEdges <= sh_q;
			end else if (ptr_q == REG_ENABLE) begin
				cfgL_q.powerOnBit <= sh_q[EN_PON_BIT];
				cfgL_q.measureEnable <= sh_q[EN_MEAS_BIT];
				cfgL_q.waitEnable <= sh_q[EN_WAIT_BIT];
				cfgL_q.diodeMux <= sh_q[EN_MUX_BIT];
			end else if (ptr_q == REG_STEP_COUNT) begin
				cfgL_q.stepCount <= sh_q;
			end else if (ptr_q == REG_WAIT) begin
				cfgL_q.interMeasureWait <= sh_q;
			end else if (ptr_q == REG_GAIN) begin
				cfgL_q.gain <= sh_q[GAIN_W-1:0]; // see R10
			end else if (ptr_q == REG_CFG_SLEEP) begin
				cfgL_q.sleepAfterIrq <= sh_q[SAI_BIT];
			end else if (ptr_q == REG_STEP_SIZE_L) begin
				stepSizeLo_q <= sh_q;
			end else if (ptr_q == REG_STEP_SIZE_H) begin
				cfgL_q.stepSize <= {sh_q, stepSizeLo_q}; // see R21
			end else if (ptr_q == REG_INT_ENABLE) begin
				cfgL_q.irqEnable <= sh_q[INT_EN_BIT];
			end
		end
	end

	// ---------------- clk domain logic ----------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{cfgS1, cfgS2, cfgS3, clrS1, clrS2, clrS3} <= 6'h00;
			{gpS1, gpS2, gpS3} <= 3'h0;
		end else begin
			cfgS1 <= cfgTgl_q;
			cfgS2 <= cfgS1;
			cfgS3 <= cfgS2;
			clrS1 <= clrTgl_q;
			clrS2 <= clrS1;
			clrS3 <= clrS2;
			gpS1 <= gpioIn;
			gpS2 <= gpS1;
			gpS3 <= gpS2;
		end
	end

	// config copy and clear pulses
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= '0;
			clrEvt_q <= 2'h0;
		end else begin
			if (cfgS2 != cfgS3) begin
				cfg_q <= cfgL_q;
			end
			clrEvt_q <= (clrS2 != clrS3) ? clrBits_q : 2'h0;
		end
	end

	assign clrSleep = clrEvt_q[0];
	assign clrInt = clrEvt_q[1];
	assign tick = (base_q == BASE_LAST);
	assign gpEdge = gpS2 & ~gpS3;
	assign syncMode = (cfg_q.intMode == MODE_START_SYNC) ||
		(cfg_q.intMode == MODE_START_STOP_SYNC);
	assign integDone = (ms_q == MS_INTEG) &&
		((cfg_q.intMode == MODE_START_STOP_SYNC) ?
		(gpEdge && (edges_q + 8'h01 >= cfg_q.syncEdges)) : // see R15
		(tick && size_q == cfg_q.stepSize && count_q == cfg_q.stepCount)); // see R24
	assign waitDone = (ms_q == MS_WAIT) && tick && size_q == WAIT_UNIT_STEPS &&
		count_q == cfg_q.interMeasureWait; // see R11
	assign irqEvt = integDone && cfg_q.irqEnable;

	// power states
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwr_q <= PS_INIT;
			initCnt_q <= '0;
			initDone_q <= 1'b0;
		end else begin
			case (pwr_q)
				PS_INIT: begin
					initCnt_q <= initCnt_q + 1'b1; // see R1
					if (initCnt_q == INIT_LAST) begin
						pwr_q <= PS_SLEEP; // see R3
						initDone_q <= 1'b1;
					end
				end
				default: begin
					if (irqSleep_q || !cfg_q.powerOnBit) begin
						pwr_q <= PS_SLEEP; // see R8
					end else if (cfg_q.measureEnable) begin
						pwr_q <= PS_ACTIVE; // see R6
					end else begin
						pwr_q <= PS_IDLE; // see R5
					end
				end
			endcase
		end
	end

	// measurement sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ms_q <= MS_OFF;
		end else if (pwr_q != PS_ACTIVE || irqSleep_q || (irqEvt && cfg_q.sleepAfterIrq)) begin
			ms_q <= MS_OFF; // see R7
		end else begin
			case (ms_q)
				MS_OFF: ms_q <= syncMode ? MS_ARM : MS_INTEG; // see R13
				MS_ARM: if (gpEdge) ms_q <= MS_INTEG; // see R14
				MS_INTEG: begin
					if (integDone) begin
						ms_q <= cfg_q.waitEnable ? MS_WAIT : (syncMode ? MS_ARM : MS_INTEG);
					end
				end
				default: if (waitDone) ms_q <= syncMode ? MS_ARM : MS_INTEG;
			endcase
		end
	end

	// step timers for integration and wait
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			base_q <= '0;
			size_q <= 16'h0000;
			count_q <= 8'h00;
		end else if ((ms_q != MS_INTEG && ms_q != MS_WAIT) || integDone || waitDone) begin
			base_q <= '0;
			size_q <= 16'h0000;
			count_q <= 8'h00;
		end else begin
			base_q <= tick ? '0 : base_q + 1'b1;
			if (tick) begin
				if (size_q == ((ms_q == MS_WAIT) ? WAIT_UNIT_STEPS : cfg_q.stepSize)) begin
					size_q <= 16'h0000;
					count_q <= count_q + 8'h01;
				end else begin
					size_q <= size_q + 16'h0001;
				end
			end
		end
	end

	// elapsed time and edge count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			elapsed_q <= 24'h000000;
			edges_q <= 8'h00;
		end else if (ms_q != MS_INTEG || integDone) begin
			elapsed_q <= 24'h000000;
			edges_q <= 8'h00;
		end else begin
			if (tick && elapsed_q != ELAPSED_MAX) begin
				elapsed_q <= elapsed_q + 24'h000001; // see R16
			end
			if (gpEdge) begin
				edges_q <= edges_q + 8'h01;
			end
		end
	end

	// channel counters and result snapshot
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			snapTgl_q <= 1'b0;
			elapsedSnap_q <= 24'h000000;
			for (int i = 0; i < NUM_CH; i++) begin
				cnt_q[i] <= 16'h0000;
				chData_q[i] <= 16'h0000;
			end
		end else begin
			if (integDone) begin
				snapTgl_q <= ~snapTgl_q;
				elapsedSnap_q <= elapsed_q;
			end
			for (int i = 0; i < NUM_CH; i++) begin
				if (integDone) begin
					chData_q[i] <= cnt_q[i]; // see R10
				end
				if (ms_q != MS_INTEG || integDone) begin
					cnt_q[i] <= 16'h0000;
				end else if (convPulse[i] && cnt_q[i] != CH_MAX) begin
					cnt_q[i] <= cnt_q[i] + 16'h0001;
				end
			end
		end
	end

	// status flags, set beats clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqSleep_q <= 1'b0;
			intFlag_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			if (irqEvt && cfg_q.sleepAfterIrq) begin
				irqSleep_q <= 1'b1; // see R7
			end else if (clrSleep) begin
				irqSleep_q <= 1'b0; // see R9
			end
			if (irqEvt) begin
				intFlag_q <= 1'b1;
			end else if (clrInt) begin
				intFlag_q <= 1'b0;
			end
			if (integDone) begin
				ready_q <= 1'b1;
			end else if (ms_q == MS_INTEG) begin
				ready_q <= 1'b0;
			end
		end
	end

	// front-end controls and interrupt pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqN <= 1'b1;
			oscEnable <= 1'b0;
			convRun <= 1'b0;
			diodeMuxEn <= 1'b0;
			chanGain <= '0;
		end else begin
			irqN <= ~(intFlag_q || (syncMode && ms_q == MS_INTEG)); // see R17
			oscEnable <= (pwr_q == PS_IDLE) || (pwr_q == PS_ACTIVE); // see R3, R5
			convRun <= (ms_q == MS_INTEG) && !integDone;
			diodeMuxEn <= cfg_q.diodeMux; // see R12
			chanGain <= cfg_q.gain;
		end
	end
endmodule
`default_nettype wire

// >>> ssc_pkg.sv
`default_nettype none
package ssc_pkg;
	// serial slave identity and register offsets
	localparam logic [6:0] I2C_DEV_ADDR = 7'h39;
	localparam logic [7:0] REG_ELAPSED_INTEGRATION_L = 8'h63;
	localparam logic [7:0] REG_ELAPSED_INTEGRATION_M = 8'h64;
	localparam logic [7:0] REG_ELAPSED_INTEGRATION_H = 8'h65;
	localparam logic [7:0] REG_CONFIG = 8'h70;
	localparam logic [7:0] REG_STAT = 8'h71;
	localparam logic [7:0] REG_EDGE = 8'h72;
	localparam logic [7:0] REG_ENABLE = 8'h80;
	localparam logic [7:0] REG_STEP_COUNT = 8'h81;
	localparam logic [7:0] REG_WAIT = 8'h83;
	localparam logic [7:0] REG_STATUS = 8'h93;
	localparam logic [7:0] REG_CH0_L = 8'h95;
	localparam logic [7:0] REG_SLEEP_STAT = 8'hA7;
	localparam logic [7:0] REG_GAIN = 8'hAA;
	localparam logic [7:0] REG_CFG_SLEEP = 8'hAC;
	localparam logic [7:0] REG_STEP_SIZE_L = 8'hCA;
	localparam logic [7:0] REG_STEP_SIZE_H = 8'hCB;
	localparam logic [7:0] REG_INT_ENABLE = 8'hF9;
	localparam logic [7:0] REG_CLEAR = 8'hFA;
	// bit positions
	localparam int EN_PON_BIT = 0;
	localparam int EN_MEAS_BIT = 1;
	localparam int EN_WAIT_BIT = 3;
	localparam int EN_MUX_BIT = 4;
	localparam int SAI_BIT = 4;
	localparam int SLEEP_FLAG_BIT = 0;
	localparam int READY_BIT = 0;
	localparam int INT_FLAG_BIT = 3;
	localparam int INT_EN_BIT = 3;
	localparam int CLR_SLEEP_BIT = 0;
	localparam int CLR_INT_BIT = 1;
	localparam int GAIN_W = 5;
	// integration modes
	localparam logic [1:0] MODE_FREE = 2'h0;
	localparam logic [1:0] MODE_START_SYNC = 2'h1;
	localparam logic [1:0] MODE_START_STOP_SYNC = 2'h3;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int INIT_TIME_NS = 200000;
	localparam int INIT_CYC = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BASE_TIME_NS = 2780;
	localparam int BASE_CYC = (BASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] WAIT_UNIT_STEPS = 16'h03E7;
	typedef struct packed {
		logic powerOnBit;
		logic measureEnable;
		logic waitEnable;
		logic diodeMux;
		logic [1:0] intMode;
		logic [7:0] syncEdges;
		logic [7:0] stepCount;
		logic [15:0] stepSize;
		logic [7:0] interMeasureWait;
		logic sleepAfterIrq;
		logic irqEnable;
		logic [GAIN_W-1:0] gain;
	} ssc_cfg_t;
	typedef enum logic [1:0] {PS_INIT, PS_SLEEP, PS_IDLE, PS_ACTIVE} ssc_pwr_t;
	typedef enum logic [1:0] {MS_OFF, MS_ARM, MS_INTEG, MS_WAIT} ssc_meas_t;
	typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_REG, LK_WR, LK_RD} ssc_link_t;
endpackage
`default_nettype wire

// >>> ssc_control_sva.sv
`default_nettype none
module ssc_control_chk
	import ssc_pkg::*;
#(
	parameter int NUM_CH = 6
) (
	// clocks and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic linkClk,
	// serial link and pins
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic gpioIn,
	input wire logic irqN,
	// converter front end
	input wire logic [NUM_CH-1:0] convPulse,
	input wire logic oscEnable,
	input wire logic convRun,
	input wire logic diodeMuxEn,
	input wire logic [GAIN_W-1:0] chanGain
);
	logic [11:0] initCnt_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) initCnt_q <= 12'h000;
		else if (initCnt_q < 12'(INIT_CYC)) initCnt_q <= initCnt_q + 12'h001;
	end
	chk_reset_quiet: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> irqN && !convRun && !oscEnable && !sdaOe) else $error("reset quiet");
	chk_init_nak: assert property (@(posedge clk) disable iff (!nrst)
		initCnt_q < 12'(INIT_CYC - 10) |-> !sdaOe) else $error("ack in init");
	chk_init_noirq: assert property (@(posedge clk) disable iff (!nrst)
		initCnt_q < 12'(INIT_CYC) |-> irqN) else $error("irq in init");
	chk_init_sleep: assert property (@(posedge clk) disable iff (!nrst)
		initCnt_q < 12'(INIT_CYC) |-> !oscEnable && !convRun) else $error("awake in init");
	chk_run_osc: assert property (@(posedge clk) disable iff (!nrst)
		!oscEnable [*3] |-> !convRun) else $error("run without osc");
	chk_run_first: assert property (@(posedge clk) disable iff (!nrst)
		$rose(convRun) |-> $past(oscEnable)) else $error("run before active");
	chk_sda_low: assert property (@(posedge linkClk) disable iff (!nrst)
		!sdaOut) else $error("sda driven high");
	chk_sda_steady: assert property (@(posedge linkClk) disable iff (!nrst)
		sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("sda moved in high");
	chk_ack_low: assert property (@(posedge linkClk) disable iff (!nrst)
		$rose(sdaOe) |-> !sclIn) else $error("sda drive in high");
	cover property (@(posedge clk) disable iff (!nrst) $rose(convRun));
	cover property (@(posedge clk) disable iff (!nrst) $fell(oscEnable) && !irqN);
	cover property (@(posedge linkClk) disable iff (!nrst) $rose(sdaOe));
endmodule
bind ssc_control ssc_control_chk #(.NUM_CH(NUM_CH)) ssc_control_chk_inst (.clk, .nrst,
	.linkClk, .sclIn, .sdaIn, .sdaOut, .sdaOe, .gpioIn, .irqN, .convPulse, .oscEnable,
	.convRun, .diodeMuxEn, .chanGain);
`default_nettype wire

// >>> ssc_host.sv
`default_nettype none
module ssc_host (
	// serial lines
	input wire logic linkClk,
	input wire logic sdaWire,
	output logic scl,
	output logic sdaRel
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sdaRel = 1'b1;
	end
	task automatic tk();
		repeat (8) @(negedge linkClk);
	endtask
	task automatic go();
		sdaRel = 1'b1;
		tk();
		scl = 1'b1;
		tk();
		sdaRel = 1'b0;
		tk();
		scl = 1'b0;
	endtask
	task automatic halt();
		tk();
		sdaRel = 1'b0;
		tk();
		scl = 1'b1;
		tk();
		sdaRel = 1'b1;
		tk();
	endtask
	task automatic bx(input logic b, output logic s);
		tk();
		sdaRel = b;
		tk();
		scl = 1'b1;
		tk();
		s = sdaWire;
		tk();
		scl = 1'b0;
	endtask
	task automatic tx(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bx(v[i], s);
		bx(1'b1, s);
		ack = !s;
	endtask
	task automatic xfer(input logic [6:0] ad, input logic [7:0] r, input logic [15:0] d,
		input logic hasReg, input int nw, input int nr, output logic [15:0] q, output logic ack);
		logic k;
		q = 16'h0000;
		ack = 1'b1;
		go();
		if (hasReg) begin
			tx({ad, 1'b0}, ack);
			if (!ack) begin
				halt();
				return;
			end
			tx(r, k);
			for (int i = 0; i < nw; i++) tx(d[8*i+:8], k);
			if (nr > 0) go();
		end
		if (nr > 0) begin
			tx({ad, 1'b1}, k);
			ack = ack & k;
			for (int i = 0; i < nr; i++) begin
				for (int j = 7; j >= 0; j--) bx(1'b1, q[8*i+j]);
				bx(i == nr - 1, k);
			end
		end
		halt();
	endtask
endmodule
`default_nettype wire

// >>> tb_ssc_control.sv
`default_nettype none
module tb_ssc_control
	import ssc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic linkClk = 1'b0;
	logic nrst, sclIn, sdaRel, gpioIn, sdaOut, sdaOe, irqN, oscEnable, convRun, diodeMuxEn, a;
	logic [5:0] convPulse = 6'h00;
	logic [GAIN_W-1:0] chanGain;
	logic [15:0] q;
	logic [15:0] runCnt = 16'h0000;
	logic [15:0] lastRun = 16'h0000;
	wire sdaIn;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	assign sdaIn = sdaRel & !sdaOe;
	always #50 clk = ~clk;
	always #40 linkClk = ~linkClk;
	ssc_control #(.NUM_CH(6)) ssc_control_inst (.clk, .nrst, .linkClk, .sclIn, .sdaIn,
		.sdaOut, .sdaOe, .gpioIn, .irqN, .convPulse, .oscEnable, .convRun, .diodeMuxEn,
		.chanGain);
	ssc_host ssc_host_inst (.linkClk, .sdaWire(sdaIn), .scl(sclIn), .sdaRel);
	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] r, input logic [15:0] d, input int n, input logic e);
		ssc_host_inst.xfer(I2C_DEV_ADDR, r, d, 1'b1, n, 0, q, a);
		chk("ack", 16'(e), 16'(a));
	endtask
	task automatic rd(input logic [7:0] r, input logic h, input int n, input logic [15:0] e);
		ssc_host_inst.xfer(I2C_DEV_ADDR, r, 16'h0000, h, 0, n, q, a);
		chk("read", e, q);
	endtask
	task automatic wo(input logic v);
		int n = 0;
		while (oscEnable !== v && n < 3000) begin
			wt(1);
			n++;
		end
		chk("osc", 16'(v), 16'(oscEnable));
	endtask
	task automatic gp();
		gpioIn = 1'b1;
		wt(8);
		gpioIn = 1'b0;
		wt(8);
	endtask
	always @(negedge clk) convPulse <= ~convPulse;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (convRun === 1'b1) runCnt <= runCnt + 16'h0001;
		else if (runCnt != 16'h0000) begin
			lastRun <= runCnt;
			runCnt <= 16'h0000;
		end
		if (cyc == 40000) begin
			err_total++;
			results();
		end
	end
	initial begin
		nrst = 1'b0;
		gpioIn = 1'b0;
		wt(6);
		chk("irqN", 16'h0001, 16'(irqN));
		nrst = 1'b1;
		wr(REG_ENABLE, 16'h0001, 1, 1'b0);
		wt(2100);
		chk("osc", 16'h0000, 16'(oscEnable));
		ssc_host_inst.xfer(7'h3A, REG_GAIN, 16'h0015, 1'b1, 1, 0, q, a);
		chk("ack", 16'h0000, 16'(a));
		wr(REG_GAIN, 16'h0015, 1, 1'b1);
		wt(10);
		chk("gain", 16'h0015, 16'(chanGain));
		chk("osc", 16'h0000, 16'(oscEnable));
		wr(REG_ENABLE, 16'h0011, 1, 1'b1);
		wt(10);
		chk("osc", 16'h0001, 16'(oscEnable));
		chk("mux", 16'h0001, 16'(diodeMuxEn));
		chk("run", 16'h0000, 16'(convRun));
		wr(REG_STEP_COUNT, 16'h0001, 1, 1'b1);
		wr(REG_STEP_SIZE_L, 16'h0000, 2, 1'b1);
		wr(REG_INT_ENABLE, 16'h0008, 1, 1'b1);
		wr(REG_CFG_SLEEP, 16'h0010, 1, 1'b1);
		rd(REG_ENABLE, 1'b1, 1, 16'h0011);
		rd(8'h00, 1'b0, 1, 16'h0001);
		wr(REG_ENABLE, 16'h0013, 1, 1'b1);
		wo(1'b0);
		chk("irqN", 16'h0000, 16'(irqN));
		chk("len", 16'h0001, 16'(lastRun >= 16'h0037 && lastRun <= 16'h0039));
		rd(REG_ENABLE, 1'b1, 1, 16'h0013);
		rd(REG_SLEEP_STAT, 1'b1, 1, 16'h0001);
		wr(REG_CFG_SLEEP, 16'h0000, 1, 1'b1);
		wr(REG_ENABLE, 16'h0011, 1, 1'b1);
		chk("osc", 16'h0000, 16'(oscEnable));
		wr(REG_CLEAR, 16'h0003, 1, 1'b1);
		wo(1'b1);
		wr(REG_CONFIG, 16'h0001, 1, 1'b1);
		wr(REG_ENABLE, 16'h0013, 1, 1'b1);
		wt(100);
		chk("run", 16'h0000, 16'(convRun));
		chk("irqN", 16'h0001, 16'(irqN));
		gp();
		chk("run", 16'h0001, 16'(convRun));
		chk("irqN", 16'h0000, 16'(irqN));
		wt(100);
		chk("len", 16'h0001, 16'(lastRun >= 16'h0037 && lastRun <= 16'h0039));
		wr(REG_ENABLE, 16'h0011, 1, 1'b1);
		wr(REG_CLEAR, 16'h0002, 1, 1'b1);
		wr(REG_EDGE, 16'h0002, 1, 1'b1);
		wr(REG_CONFIG, 16'h0003, 1, 1'b1);
		wr(REG_ENABLE, 16'h0013, 1, 1'b1);
		for (int i = 0; i < 3; i++) begin
			gp();
			chk("run", 16'(i < 2), 16'(convRun));
			wt(264);
		end
		chk("len", 16'h0001, 16'(lastRun >= 16'h022B && lastRun <= 16'h0235));
		ssc_host_inst.xfer(I2C_DEV_ADDR, REG_ELAPSED_INTEGRATION_L, 16'h0000, 1'b1, 0, 2, q, a);
		chk("elapsed", 16'h0001, 16'(q >= 16'h0013 && q <= 16'h0015));
		ssc_host_inst.xfer(I2C_DEV_ADDR, REG_CH0_L, 16'h0000, 1'b1, 0, 2, q, a);
		chk("ch0", 16'h0001, 16'(q >= 16'h0116 && q <= 16'h0119));
		results();
	end
endmodule
`default_nettype wire
